// ---- hw/amux_pinmux.sv ----
`timescale 1ns/1ns
// Per-pin selection between address bus and port function
module amux_pinmux #(
  parameter int N = 12
) (
  amux_pin_if.mux pins
);
  for (genvar i = 0; i < N; i++) begin : g_pin
    always_comb begin
      if (pins.gpio_sel[i]) begin
        pins.pin_out[i] = pins.dout[i]; // see R06 R07
        pins.pin_oe[i] = pins.dir[i]; // see R06 R07
      end else begin
        pins.pin_out[i] = pins.addr[i]; // see R01 R02
        pins.pin_oe[i] = pins.bus_drive; // see R03
      end
    end
  end
endmodule

// ---- hw/amux_top.sv ----
`timescale 1ns/1ns
// How it works
// R01: Address lines six, seven carry memory address
// R02: Address lines eight to fifteen carry address
// R03: Drive-hold bit tri-states idle address, control outputs
// R04: Software should set drive-hold bit to one
// R05: All pins come up in address function
// R06: Port E bits two, three individually in/out
// R07: Port A bits zero to seven individually in/out
// R08: Cleared port E pull-up bit disables pull-up
// R09: Cleared port A pull-up bit disables pull-up
// R10: Lines 4-5 A12-13, 6-7 E2-3, 8-15 A0-7
module amux_top
  import amux_pkg::*;
#(
  parameter int NCTRL = 4
) (
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  input wire logic [15:4] ADDR_IN,
  input wire logic [NCTRL-1:0] CTRL_IN,
  input wire logic BUS_ACTIVE_IN,
  input wire logic CFG_WR_IN,
  input wire logic [3:0] CFG_SEL_IN,
  input wire logic [15:0] CFG_DATA_IN,
  input wire logic [11:0] PIN_IN,
  output logic [11:0] PIN_OUT,
  output logic [11:0] PIN_OE_OUT,
  output logic [11:0] PIN_PU_OUT,
  output logic [NCTRL-1:0] CTRL_PIN_OUT,
  output logic CTRL_PIN_OE_OUT,
  output logic [15:0] PA_GPIO_SEL_OUT,
  output logic [15:0] PA_DIR_OUT,
  output logic [15:0] PA_DOUT_OUT,
  output logic [15:0] PA_PUR_OUT,
  output logic [15:0] PE_GPIO_SEL_OUT,
  output logic [15:0] PE_DIR_OUT,
  output logic [15:0] PE_DOUT_OUT,
  output logic [15:0] PE_PUR_OUT,
  output logic DRIVE_HOLD_OUT,
  output logic [15:0] PA_PIN_STATE_OUT,
  output logic [15:0] PE_PIN_STATE_OUT
);
  // Configuration state, one copy per port, masked to existing bits
  logic [15:0] pa_sel_q, pa_sel_d;
  logic [15:0] pa_dir_q, pa_dir_d;
  logic [15:0] pa_dout_q, pa_dout_d;
  logic [15:0] pa_pur_q, pa_pur_d;
  logic [15:0] pe_sel_q, pe_sel_d;
  logic [15:0] pe_dir_q, pe_dir_d;
  logic [15:0] pe_dout_q, pe_dout_d;
  logic [15:0] pe_pur_q, pe_pur_d;
  logic drive_hold_q, drive_hold_d;

  // Registered pad controls; the pads see no combinational path
  logic [11:0] pin_out_q, pin_out_d;
  logic [11:0] pin_oe_q, pin_oe_d;
  logic [11:0] pin_pu_q, pin_pu_d;
  logic [NCTRL-1:0] ctrl_q, ctrl_d;
  logic ctrl_oe_q, ctrl_oe_d;

  // Pad levels sampled back on their port bit positions
  logic [15:0] pa_state_q, pa_state_d;
  logic [15:0] pe_state_q, pe_state_d;

  // Pull-up bit per pin, and the decoded write target
  logic [11:0] pin_pur;
  amux_sel_t sel;

  // Per-pin bundle between the gather logic and the pin mux
  amux_pin_if #(.N(AMUX_NPIN)) pins ();

  // One mux cell per pin picks address or port function
  amux_pinmux #(.N(AMUX_NPIN)) u_mux (
    .pins(pins.mux)
  );

  // Codes 9 to 15 fall outside the enum and match no target
  assign sel = amux_sel_t'(CFG_SEL_IN);

  // Configuration writes; bits with no pin stay zero
  always_comb begin
    pa_sel_d = pa_sel_q;
    pa_dir_d = pa_dir_q;
    pa_dout_d = pa_dout_q;
    pa_pur_d = pa_pur_q;
    pe_sel_d = pe_sel_q;
    pe_dir_d = pe_dir_q;
    pe_dout_d = pe_dout_q;
    pe_pur_d = pe_pur_q;
    drive_hold_d = drive_hold_q;
    // Without a strobe every register keeps its value
    if (CFG_WR_IN) begin
      if (sel == AMUX_SEL_PA_GPIO) begin
        pa_sel_d = CFG_DATA_IN & AMUX_PA_MASK;
      end else if (sel == AMUX_SEL_PA_DIR) begin
        pa_dir_d = CFG_DATA_IN & AMUX_PA_MASK; // see R07
      end else if (sel == AMUX_SEL_PA_DOUT) begin
        pa_dout_d = CFG_DATA_IN & AMUX_PA_MASK;
      end else if (sel == AMUX_SEL_PA_PUR) begin
        pa_pur_d = CFG_DATA_IN & AMUX_PA_MASK; // see R09
      end else if (sel == AMUX_SEL_PE_GPIO) begin
        pe_sel_d = CFG_DATA_IN & AMUX_PE_MASK;
      end else if (sel == AMUX_SEL_PE_DIR) begin
        pe_dir_d = CFG_DATA_IN & AMUX_PE_MASK; // see R06
      end else if (sel == AMUX_SEL_PE_DOUT) begin
        pe_dout_d = CFG_DATA_IN & AMUX_PE_MASK;
      end else if (sel == AMUX_SEL_PE_PUR) begin
        pe_pur_d = CFG_DATA_IN & AMUX_PE_MASK; // see R08
      end else if (sel == AMUX_SEL_BUS_CTL) begin
        drive_hold_d = CFG_DATA_IN[0]; // see R04
      end
    end
  end

  // Reset puts every pin back on the address bus
  // Pull-ups come up on for every existing port bit
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      pa_sel_q <= AMUX_GPIO_SEL_RST; // see R05
      pa_dir_q <= AMUX_DIR_RST;
      pa_dout_q <= AMUX_DOUT_RST;
      pa_pur_q <= AMUX_PA_PUR_RST;
      pe_sel_q <= AMUX_GPIO_SEL_RST; // see R05
      pe_dir_q <= AMUX_DIR_RST;
      pe_dout_q <= AMUX_DOUT_RST;
      pe_pur_q <= AMUX_PE_PUR_RST;
      drive_hold_q <= AMUX_DRIVE_HOLD_RST;
    end else begin
      pa_sel_q <= pa_sel_d;
      pa_dir_q <= pa_dir_d;
      pa_dout_q <= pa_dout_d;
      pa_pur_q <= pa_pur_d;
      pe_sel_q <= pe_sel_d;
      pe_dir_q <= pe_dir_d;
      pe_dout_q <= pe_dout_d;
      pe_pur_q <= pe_pur_d;
      drive_hold_q <= drive_hold_d;
    end
  end

  // Gather each pin's port bit from port A or port E
  // Port E serves only address lines six and seven
  for (genvar i = 0; i < AMUX_NPIN; i++) begin : g_map
    always_comb begin
      if (AMUX_PIN_ON_PE[i]) begin
        pins.gpio_sel[i] = pe_sel_q[AMUX_PIN_BIT[i]]; // see R10
        pins.dir[i] = pe_dir_q[AMUX_PIN_BIT[i]];
        pins.dout[i] = pe_dout_q[AMUX_PIN_BIT[i]];
        pin_pur[i] = pe_pur_q[AMUX_PIN_BIT[i]]; // see R08
      end else begin
        pins.gpio_sel[i] = pa_sel_q[AMUX_PIN_BIT[i]]; // see R10
        pins.dir[i] = pa_dir_q[AMUX_PIN_BIT[i]];
        pins.dout[i] = pa_dout_q[AMUX_PIN_BIT[i]];
        pin_pur[i] = pa_pur_q[AMUX_PIN_BIT[i]]; // see R09
      end
    end
  end

  assign pins.addr = ADDR_IN; // see R01 R02
  // Idle bus keeps driving only when drive-hold is set
  assign pins.bus_drive = BUS_ACTIVE_IN | drive_hold_q; // see R03
  // Hold comes up off, so idle lines float until software sets it

  // Pin outputs registered so the pads never see mux glitches
  always_comb begin
    pin_out_d = pins.pin_out;
    pin_oe_d = pins.pin_oe;
    pin_pu_d = pin_pur;
    ctrl_d = CTRL_IN;
    ctrl_oe_d = pins.bus_drive; // see R03
    // Port bit positions with no pin read back as zero
    pa_state_d = 16'h0000;
    pe_state_d = 16'h0000;
    for (int k = 0; k < AMUX_NPIN; k++) begin
      if (AMUX_PIN_ON_PE[k]) begin
        pe_state_d[AMUX_PIN_BIT[k]] = PIN_IN[k];
      end else begin
        pa_state_d[AMUX_PIN_BIT[k]] = PIN_IN[k];
      end
    end
  end

  // Outputs disabled and pull-ups on while in reset
  // Reset is synchronous, so one edge with reset low suffices
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      pin_out_q <= 12'h000;
      pin_oe_q <= 12'h000;
      pin_pu_q <= 12'hfff;
      ctrl_q <= '0;
      ctrl_oe_q <= 1'b0;
      pa_state_q <= 16'h0000;
      pe_state_q <= 16'h0000;
    end else begin
      pin_out_q <= pin_out_d;
      pin_oe_q <= pin_oe_d;
      pin_pu_q <= pin_pu_d;
      ctrl_q <= ctrl_d;
      ctrl_oe_q <= ctrl_oe_d;
      pa_state_q <= pa_state_d;
      pe_state_q <= pe_state_d;
    end
  end

  // Pad and readback outputs come straight from flip-flops
  assign PIN_OUT = pin_out_q;
  assign PIN_OE_OUT = pin_oe_q;
  assign PIN_PU_OUT = pin_pu_q;
  assign CTRL_PIN_OUT = ctrl_q;
  assign CTRL_PIN_OE_OUT = ctrl_oe_q;
  assign PA_GPIO_SEL_OUT = pa_sel_q;
  assign PA_DIR_OUT = pa_dir_q;
  assign PA_DOUT_OUT = pa_dout_q;
  assign PA_PUR_OUT = pa_pur_q;
  assign PE_GPIO_SEL_OUT = pe_sel_q;
  assign PE_DIR_OUT = pe_dir_q;
  assign PE_DOUT_OUT = pe_dout_q;
  assign PE_PUR_OUT = pe_pur_q;
  assign DRIVE_HOLD_OUT = drive_hold_q;
  assign PA_PIN_STATE_OUT = pa_state_q;
  assign PE_PIN_STATE_OUT = pe_state_q;
endmodule

// ---- pkg/amux_pin_if.sv ----
`timescale 1ns/1ns
// Per-pin controls from the register side to the pin mux, and its answer
interface amux_pin_if #(parameter int N = 12);
  logic [N-1:0] gpio_sel;
  logic [N-1:0] dir;
  logic [N-1:0] dout;
  logic [N-1:0] addr;
  logic bus_drive;
  logic [N-1:0] pin_out;
  logic [N-1:0] pin_oe;
  modport ctl (output gpio_sel, dir, dout, addr, bus_drive,
    input pin_out, pin_oe);
  modport mux (input gpio_sel, dir, dout, addr, bus_drive,
    output pin_out, pin_oe);
endinterface

// ---- pkg/amux_pkg.sv ----
package amux_pkg;
  // Number of shared pins: address lines 4 through 15
  localparam int AMUX_NPIN = 12;
  localparam int AMUX_ADDR_LO = 4;
  localparam int AMUX_REG_W = 16;
  // Port bits that exist on this pin group; all others read as zero
  localparam logic [15:0] AMUX_PA_MASK = 16'h30ff;
  localparam logic [15:0] AMUX_PE_MASK = 16'h000c;
  // Values after reset: address function, inputs, pull-ups on
  localparam logic [15:0] AMUX_GPIO_SEL_RST = 16'h0000;
  localparam logic [15:0] AMUX_DIR_RST = 16'h0000;
  localparam logic [15:0] AMUX_DOUT_RST = 16'h0000;
  localparam logic [15:0] AMUX_PA_PUR_RST = 16'h30ff;
  localparam logic [15:0] AMUX_PE_PUR_RST = 16'h000c;
  localparam logic AMUX_DRIVE_HOLD_RST = 1'b0;
  // Port bit used by each pin; pin i carries address line i+4
  localparam logic [3:0] AMUX_PIN_BIT [AMUX_NPIN] = '{
    4'hc, 4'hd, 4'h2, 4'h3, 4'h0, 4'h1, 4'h2, 4'h3,
    4'h4, 4'h5, 4'h6, 4'h7};
  // Pins served by port E rather than port A
  localparam logic [11:0] AMUX_PIN_ON_PE = 12'h00c;

  // Targets of the configuration write port
  typedef enum logic [3:0] {
    AMUX_SEL_PA_GPIO,
    AMUX_SEL_PA_DIR,
    AMUX_SEL_PA_DOUT,
    AMUX_SEL_PA_PUR,
    AMUX_SEL_PE_GPIO,
    AMUX_SEL_PE_DIR,
    AMUX_SEL_PE_DOUT,
    AMUX_SEL_PE_PUR,
    AMUX_SEL_BUS_CTL
  } amux_sel_t;
endpackage

// ---- tb/amux_mem_model.sv ----
`timescale 1ns/1ns
// Memory pads: it only listens, so a released pad without pull-up
// wanders every cycle and a stale level never passes for a driven one
module amux_mem_model (
  input wire logic clk_in,
  input wire logic [11:0] pin_in,
  input wire logic [11:0] oe_in,
  input wire logic [11:0] pu_in,
  output logic [11:0] pad_out
);
  logic [11:0] wander_q = 12'h5a5;
  always @(posedge clk_in) wander_q <= ~wander_q;
  assign pad_out = (oe_in & pin_in) | (~oe_in & (pu_in | wander_q));
endmodule

// ---- tb/amux_top_sva.sv ----
`timescale 1ns/1ns
module amux_top_sva (
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  input wire logic [15:4] ADDR_IN,
  input wire logic BUS_ACTIVE_IN,
  input wire logic [11:0] PIN_IN,
  input wire logic [15:0] PA_PIN_STATE_OUT,
  input wire logic [15:0] PE_PIN_STATE_OUT,
  input wire logic [11:0] PIN_OUT,
  input wire logic [11:0] PIN_OE_OUT,
  input wire logic CTRL_PIN_OE_OUT,
  input wire logic [15:0] PA_GPIO_SEL_OUT,
  input wire logic [15:0] PA_DIR_OUT,
  input wire logic [15:0] PE_GPIO_SEL_OUT,
  input wire logic [15:0] PE_DIR_OUT,
  input wire logic DRIVE_HOLD_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);
  // Every pin on the address bus with nothing keeping it driven
  sequence idle_bus;
    !PA_GPIO_SEL_OUT && !PE_GPIO_SEL_OUT && !BUS_ACTIVE_IN && !DRIVE_HOLD_OUT;
  endsequence
  // Pins answer one edge after their cause
  a_addr_mid: assert property (!PE_GPIO_SEL_OUT[3:2] |=>
    PIN_OUT[3:2] == 2'($past(ADDR_IN) >> 2)) else $error("addr mid");
  a_addr_high: assert property (!PA_GPIO_SEL_OUT[7:0] |=>
    PIN_OUT[11:4] == 8'($past(ADDR_IN) >> 4)) else $error("addr high");
  a_idle_float: assert property (idle_bus |=>
    !PIN_OE_OUT && !CTRL_PIN_OE_OUT) else $error("idle driven");
  a_hold_drive: assert property (DRIVE_HOLD_OUT &&
    !PA_GPIO_SEL_OUT[7:0] |=> &PIN_OE_OUT[11:4] && CTRL_PIN_OE_OUT)
    else $error("hold lost");
  a_bus_drive: assert property (BUS_ACTIVE_IN |=>
    CTRL_PIN_OE_OUT) else $error("control idle");
  a_reset_addr: assert property ($rose(NRST_IN) |->
    !PA_GPIO_SEL_OUT && !PE_GPIO_SEL_OUT && !PIN_OE_OUT) else $error("reset");
  a_pe_port: assert property (&PE_GPIO_SEL_OUT[3:2] |=>
    PIN_OE_OUT[3:2] == 2'($past(PE_DIR_OUT) >> 2)) else $error("pe dir");
  a_pa_port: assert property (&PA_GPIO_SEL_OUT[7:0] |=>
    PIN_OE_OUT[11:4] == 8'($past(PA_DIR_OUT))) else $error("pa dir");
  // Pad levels land on their own port bit, all others stay zero
  a_pin_state: assert property (1'b1 |=>
    PA_PIN_STATE_OUT == {2'b00, $past(PIN_IN[1:0]), 4'h0, $past(PIN_IN[11:4])}
    && PE_PIN_STATE_OUT == {12'h000, $past(PIN_IN[3:2]), 2'b00})
    else $error("pin state");
endmodule
bind amux_top amux_top_sva u_amux_top_sva (.CLK_IN(CLK_IN),
  .NRST_IN(NRST_IN), .ADDR_IN(ADDR_IN), .BUS_ACTIVE_IN(BUS_ACTIVE_IN),
  .PIN_IN(PIN_IN), .PA_PIN_STATE_OUT(PA_PIN_STATE_OUT),
  .PE_PIN_STATE_OUT(PE_PIN_STATE_OUT),
  .PIN_OUT(PIN_OUT), .PIN_OE_OUT(PIN_OE_OUT),
  .CTRL_PIN_OE_OUT(CTRL_PIN_OE_OUT), .PA_GPIO_SEL_OUT(PA_GPIO_SEL_OUT),
  .PA_DIR_OUT(PA_DIR_OUT), .PE_GPIO_SEL_OUT(PE_GPIO_SEL_OUT),
  .PE_DIR_OUT(PE_DIR_OUT), .DRIVE_HOLD_OUT(DRIVE_HOLD_OUT));

// ---- tb/test_address_pin_gpio_mux.sv ----
`timescale 1ns/1ns
module test_address_pin_gpio_mux;
  localparam int NCYC = 2000;
  logic CLK_IN = 1'b0, NRST_IN = 1'b0, BUS_ACTIVE_IN = 1'b0, CFG_WR_IN = 1'b0;
  logic [3:0] CTRL_IN = 4'h0, CFG_SEL_IN = 4'h0;
  logic [15:4] ADDR_IN = 12'h000;
  logic [15:0] CFG_DATA_IN = 16'h0000;
  logic [11:0] PIN_IN, PIN_OUT, PIN_OE_OUT, PIN_PU_OUT;
  logic [3:0] CTRL_PIN_OUT;
  logic CTRL_PIN_OE_OUT, DRIVE_HOLD_OUT, dh;
  logic [15:0] PA_GPIO_SEL_OUT, PA_DIR_OUT, PA_DOUT_OUT, PA_PUR_OUT;
  logic [15:0] PE_GPIO_SEL_OUT, PE_DIR_OUT, PE_DOUT_OUT, PE_PUR_OUT;
  logic [15:0] sh [2][4];
  logic [169:0] q [$];
  int mismatches = 0, checked = 0;
  // Pads, control pins and the register readbacks in one compared word; pin state readbacks unchecked
  wire [169:0] obs = {PIN_OUT, PIN_OE_OUT, PIN_PU_OUT, CTRL_PIN_OE_OUT,
    CTRL_PIN_OUT, DRIVE_HOLD_OUT, PA_GPIO_SEL_OUT, PA_DIR_OUT, PA_DOUT_OUT,
    PA_PUR_OUT, PE_GPIO_SEL_OUT, PE_DIR_OUT, PE_DOUT_OUT, PE_PUR_OUT};
  always #5 CLK_IN = ~CLK_IN;
  amux_top u_amux_top (.CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .ADDR_IN(ADDR_IN),
    .CTRL_IN(CTRL_IN), .BUS_ACTIVE_IN(BUS_ACTIVE_IN), .CFG_WR_IN(CFG_WR_IN),
    .CFG_SEL_IN(CFG_SEL_IN), .CFG_DATA_IN(CFG_DATA_IN), .PIN_IN(PIN_IN),
    .PIN_OUT(PIN_OUT), .PIN_OE_OUT(PIN_OE_OUT), .PIN_PU_OUT(PIN_PU_OUT),
    .CTRL_PIN_OUT(CTRL_PIN_OUT), .CTRL_PIN_OE_OUT(CTRL_PIN_OE_OUT),
    .PA_GPIO_SEL_OUT(PA_GPIO_SEL_OUT), .PA_DIR_OUT(PA_DIR_OUT),
    .PA_DOUT_OUT(PA_DOUT_OUT), .PA_PUR_OUT(PA_PUR_OUT),
    .PE_GPIO_SEL_OUT(PE_GPIO_SEL_OUT), .PE_DIR_OUT(PE_DIR_OUT),
    .PE_DOUT_OUT(PE_DOUT_OUT), .PE_PUR_OUT(PE_PUR_OUT),
    .DRIVE_HOLD_OUT(DRIVE_HOLD_OUT), .PA_PIN_STATE_OUT(),
    .PE_PIN_STATE_OUT());
  amux_mem_model u_amux_mem_model (.clk_in(CLK_IN), .pin_in(PIN_OUT),
    .oe_in(PIN_OE_OUT), .pu_in(PIN_PU_OUT), .pad_out(PIN_IN));
  task automatic check(string nm, logic [169:0] seen, logic [169:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Pins one edge ahead from the shadow registers; pin i is line i+4
  function automatic logic [36:0] ref_pins(logic [15:4] a, logic ba);
    logic [11:0] o, e, u;
    int b, p;
    for (int i = 0; i < 12; i++) begin
      p = int'(i == 2 || i == 3);
      b = i < 2 ? i + 12 : (p == 1 ? i : i - 4);
      o[i] = sh[p][0][b] ? sh[p][2][b] : a[i + 4];
      e[i] = sh[p][0][b] ? sh[p][1][b] : ba | dh;
      u[i] = sh[p][3][b];
    end
    return {o, e, u, ba | dh};
  endfunction
  // Outputs at a falling edge settle from the note before the newest
  always @(negedge CLK_IN) if (q.size() > 1)
    check("pins", obs, q.pop_front());
  // Random bus activity with hold off first, then hold set, then random writes
  initial begin
    logic [15:4] a;
    logic ba, w;
    logic [3:0] s, c;
    logic [15:0] d;
    logic [36:0] r;
    void'($urandom(32'hd058ed90));
    sh[0] = '{16'h0000, 16'h0000, 16'h0000, 16'h30ff};
    sh[1] = '{16'h0000, 16'h0000, 16'h0000, 16'h000c};
    dh = 1'b0;
    // Reset low for 16 edges; outputs looked at once settled
    repeat (15) @(posedge CLK_IN);
    @(negedge CLK_IN);
    check("reset", obs, {36'h000000fff, 6'h00, 48'h0, 16'h30ff, 48'h0,
      16'h000c});
    for (int n = 0; n < NCYC; n++) begin
      @(posedge CLK_IN);
      a = 12'($urandom);
      ba = 1'($urandom);
      c = 4'($urandom);
      w = n == 40 || (n > 40 && $urandom_range(0, 3) == 0);
      s = n == 40 ? 4'h8 : 4'($urandom_range(0, 9));
      d = $urandom_range(0, 1) ? 16'hffff : 16'($urandom);
      if (n == 40) d = 16'h0001;
      // Pins use the state before this write, readbacks the state after
      r = ref_pins(a, ba);
      if (w && s < 8) sh[s / 4][s % 4] = d & (s < 4 ? 16'h30ff : 16'h000c);
      if (w && s == 8) dh = d[0];
      q.push_back({r, c, dh, sh[0][0], sh[0][1], sh[0][2], sh[0][3],
        sh[1][0], sh[1][1], sh[1][2], sh[1][3]});
      NRST_IN <= 1'b1;
      ADDR_IN <= a;
      BUS_ACTIVE_IN <= ba;
      CTRL_IN <= c;
      CFG_WR_IN <= w;
      CFG_SEL_IN <= s;
      CFG_DATA_IN <= d;
    end
    // One more cycle before the verdict; the last note stays queued and is never compared
    @(posedge CLK_IN);
    @(negedge CLK_IN);
    complete_run();
  end
  // A hang ends the run as a mismatch
  initial begin
    #(4 * NCYC * 10);
    mismatches++;
    complete_run();
  end
endmodule
